// ### shared/spi_cs_pkg.sv
/*
  Constants of the serial port control and status logic.
  Assumes a byte-wide special-function bus and a separate shift engine.
*/
package spi_cs_pkg;

  localparam logic [7:0] CSR_ADDR  = 8'hf8;
  localparam logic [7:0] DATA_ADDR = 8'ha3;

  localparam int DONE_BIT  = 7;
  localparam int COLL_BIT  = 6;
  localparam int FAULT_BIT = 5;
  localparam int OVR_BIT   = 4;
  localparam int MODE_HI   = 3;
  localparam int MODE_LO   = 2;
  localparam int TXE_BIT   = 1;
  localparam int EN_BIT    = 0;

  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    MODE_THREE_WIRE = 2'b00,
    MODE_SELECT_IN  = 2'b01,
    MODE_DRIVE_LOW  = 2'b10,
    MODE_DRIVE_HIGH = 2'b11
  } sel_mode_t;

  localparam sel_mode_t MODE_RST = MODE_SELECT_IN;
  localparam logic      TXE_RST  = 1'b1;
  localparam logic      FLAG_RST = 1'b0;
  localparam logic      EN_RST   = 1'b0;

endpackage

// ### shared/link_xfer_if.sv
/*
  Signals that cross between the system-clock logic and the link-clock logic.
  Every crossing is a toggle or a word held stable behind a toggle.
*/
`timescale 1ns/1ns
interface link_xfer_if;
  logic       wr_tgl;
  logic [7:0] tx_data;
  logic       ack_tgl;
  logic       end_tgl;
  logic       last_tgl;

  modport sys
  (
    output wr_tgl,
    output tx_data,
    input  ack_tgl,
    input  end_tgl,
    input  last_tgl
  );

  modport link
  (
    input  wr_tgl,
    input  tx_data,
    output ack_tgl,
    output end_tgl,
    output last_tgl
  );
endinterface

// ### core/link_events.sv
/*
  Link-clock side: offers the transmit byte to the shift engine and turns
  the engine's strobes into toggles for the system clock.
  Assumes the engine strobes are one link-clock cycle wide.
*/
`timescale 1ns/1ns
module link_events
(
  input  wire logic  link_clk,
  input  wire logic  rstn,
  link_xfer_if.link  lk,
  input  wire logic  tx_load,
  input  wire logic  xfer_end,
  input  wire logic  last_bit,
  output logic       tx_valid,
  output logic [7:0] tx_data
);

  typedef struct packed {
    logic [1:0] wr_s;
    logic       ack_tgl;
    logic       end_tgl;
    logic       last_tgl;
  } link_state_t;

  link_state_t s;
  link_state_t n;

  // A byte is on offer while the write toggle seen here differs from ours.
  assign tx_valid    = s.wr_s[1] ^ s.ack_tgl;
  assign tx_data     = lk.tx_data;
  assign lk.ack_tgl  = s.ack_tgl;
  assign lk.end_tgl  = s.end_tgl;
  assign lk.last_tgl = s.last_tgl;

  always_comb
  begin
    n = s;
    n.wr_s = {s.wr_s[0], lk.wr_tgl};
    if (tx_load && tx_valid)
    begin
      n.ack_tgl = ~s.ack_tgl;
    end
    if (xfer_end)
    begin
      n.end_tgl = ~s.end_tgl;
    end
    if (last_bit)
    begin
      n.last_tgl = ~s.last_tgl;
    end
  end

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  a_load_acks :
    assert property (@(posedge link_clk) disable iff (!rstn)
      tx_load && tx_valid |=> !tx_valid)
    else $error("Loaded byte still on offer.");

endmodule

// ### core/spi_control_status.sv
/*
  Control and status register of the serial port with its sticky flags,
  select pin handling and transmit buffer.
  Assumes a byte-wide special-function bus on clk, and a shift engine
  on link_clk that strobes load, last bit and transfer end.
*/
`timescale 1ns/1ns
module spi_control_status
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_bit_wr,
  input  wire logic       sfr_bit_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_rd_hit,
  input  wire logic       master_enable,
  input  wire logic       rx_buffer_full,
  input  wire logic       irq_enable,
  output logic            irq_request,
  output logic            port_enable,
  input  wire logic       select_pin_in,
  output logic            select_pin_out,
  output logic            select_pin_oe,
  output logic            select_n_to_engine,
  input  wire logic       link_clk,
  input  wire logic       tx_load,
  input  wire logic       xfer_end,
  input  wire logic       last_bit,
  output logic            tx_valid,
  output logic      [7:0] tx_data
);

  typedef struct packed {
    logic                  done;
    logic                  coll;
    logic                  fault;
    logic                  ovr;
    spi_cs_pkg::sel_mode_t mode;
    logic                  txe;
    logic                  en;
    logic [7:0]            txbuf;
    logic                  wr_tgl;
    logic [1:0]            ack_s;
    logic                  ack_q;
    logic [1:0]            end_s;
    logic                  end_q;
    logic [1:0]            last_s;
    logic                  last_q;
    logic [1:0]            sel_s;
    logic [7:0]            rdata;
    logic                  rd_hit;
  } sys_state_t;

  localparam sys_state_t SYS_RST = '{
    done:    spi_cs_pkg::FLAG_RST,
    coll:    spi_cs_pkg::FLAG_RST,
    fault:   spi_cs_pkg::FLAG_RST,
    ovr:     spi_cs_pkg::FLAG_RST,
    mode:    spi_cs_pkg::MODE_RST,
    txe:     spi_cs_pkg::TXE_RST,
    en:      spi_cs_pkg::EN_RST,
    sel_s:   2'h3,
    default: '0
  };

  sys_state_t s;
  sys_state_t n;

  link_xfer_if lk ();

  logic [7:0] csr_now;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic       csr_wr;
  logic       csr_bit_wr;
  logic       dat_wr;
  logic       ack_ev;
  logic       end_ev;
  logic       last_ev;
  logic       sel_lvl;
  logic       set_done;
  logic       set_coll;
  logic       set_fault;
  logic       set_ovr;

  link_events u_link
  (
    .link_clk (link_clk),
    .rstn     (rstn),
    .lk       (lk.link),
    .tx_load  (tx_load),
    .xfer_end (xfer_end),
    .last_bit (last_bit),
    .tx_valid (tx_valid),
    .tx_data  (tx_data)
  );

  assign lk.wr_tgl  = s.wr_tgl;
  assign lk.tx_data = s.txbuf;

  // Edge detectors look only at the second stage of each synchroniser.
  assign ack_ev  = s.ack_s[1] ^ s.ack_q;
  assign end_ev  = s.end_s[1] ^ s.end_q;
  assign last_ev = s.last_s[1] ^ s.last_q;
  assign sel_lvl = s.sel_s[1];

  assign csr_now = {s.done, s.coll, s.fault, s.ovr, s.mode, s.txe, s.en};

  // Byte writes and single-bit writes share one mask.
  assign csr_wr     = sfr_wr && (sfr_addr == spi_cs_pkg::CSR_ADDR);
  assign csr_bit_wr = sfr_bit_wr &&
                      (sfr_addr[7:3] == spi_cs_pkg::CSR_ADDR[7:3]);
  assign dat_wr     = sfr_wr && (sfr_addr == spi_cs_pkg::DATA_ADDR);

  always_comb
  begin
    wmask = 8'h00;
    wval  = 8'h00;
    if (csr_wr)
    begin
      wmask = 8'hff;
      wval  = sfr_wdata;
    end
    else if (csr_bit_wr)
    begin
      wmask = 8'h01 << sfr_addr[2:0];
      wval  = {8{sfr_bit_wdata}};
    end
  end

  assign set_done  = s.en && end_ev;
  assign set_coll  = dat_wr && !s.txe;
  assign set_fault = s.en && master_enable && !sel_lvl &&
                     (s.mode == spi_cs_pkg::MODE_SELECT_IN);
  assign set_ovr   = s.en && last_ev && !master_enable && rx_buffer_full;

  always_comb
  begin
    n = s;
    n.ack_s  = {s.ack_s[0], lk.ack_tgl};
    n.ack_q  = s.ack_s[1];
    n.end_s  = {s.end_s[0], lk.end_tgl};
    n.end_q  = s.end_s[1];
    n.last_s = {s.last_s[0], lk.last_tgl};
    n.last_q = s.last_s[1];
    n.sel_s  = {s.sel_s[0], select_pin_in};

    // Software writes first, hardware sets after, so a set is never lost.
    if (wmask[spi_cs_pkg::DONE_BIT])
    begin
      n.done = wval[spi_cs_pkg::DONE_BIT];
    end
    if (wmask[spi_cs_pkg::COLL_BIT])
    begin
      n.coll = wval[spi_cs_pkg::COLL_BIT];
    end
    if (wmask[spi_cs_pkg::FAULT_BIT])
    begin
      n.fault = wval[spi_cs_pkg::FAULT_BIT];
    end
    if (wmask[spi_cs_pkg::OVR_BIT])
    begin
      n.ovr = wval[spi_cs_pkg::OVR_BIT];
    end
    // The mode field is rebuilt whole so that the enum is never written bit by bit.
    if (wmask[spi_cs_pkg::MODE_HI] || wmask[spi_cs_pkg::MODE_LO])
    begin
      n.mode = spi_cs_pkg::sel_mode_t'({
        wmask[spi_cs_pkg::MODE_HI] ? wval[spi_cs_pkg::MODE_HI] : s.mode[1],
        wmask[spi_cs_pkg::MODE_LO] ? wval[spi_cs_pkg::MODE_LO] : s.mode[0]});
    end
    if (wmask[spi_cs_pkg::EN_BIT])
    begin
      n.en = wval[spi_cs_pkg::EN_BIT];
    end

    if (set_done)
    begin
      n.done = 1'b1;
    end
    if (set_coll)
    begin
      n.coll = 1'b1;
    end
    if (set_fault)
    begin
      n.fault = 1'b1;
    end
    if (set_ovr)
    begin
      n.ovr = 1'b1;
    end

    // A write is taken only into an empty buffer; otherwise it is dropped.
    if (dat_wr && s.txe)
    begin
      n.txbuf  = sfr_wdata;
      n.txe    = 1'b0;
      n.wr_tgl = ~s.wr_tgl;
    end
    else if (ack_ev)
    begin
      n.txe = 1'b1;
    end

    n.rd_hit = sfr_rd && (sfr_addr == spi_cs_pkg::CSR_ADDR);
    if (sfr_rd && (sfr_addr == spi_cs_pkg::CSR_ADDR))
    begin
      n.rdata = csr_now;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= SYS_RST;
    end
    else
    begin
      s <= n;
    end
  end

  assign sfr_rdata   = s.rdata;
  assign sfr_rd_hit  = s.rd_hit;
  assign port_enable = s.en;
  assign irq_request = irq_enable && (s.done || s.coll || s.fault || s.ovr);

  // The select pin is driven only in the 1x modes and only while enabled.
  always_comb
  begin
    select_pin_oe      = 1'b0;
    select_pin_out     = 1'b0;
    select_n_to_engine = 1'b0;
    case (s.mode)
      spi_cs_pkg::MODE_THREE_WIRE:
      begin
        select_n_to_engine = 1'b0;
      end
      spi_cs_pkg::MODE_SELECT_IN:
      begin
        select_n_to_engine = sel_lvl;
      end
      spi_cs_pkg::MODE_DRIVE_LOW,
      spi_cs_pkg::MODE_DRIVE_HIGH:
      begin
        select_pin_oe  = s.en;
        select_pin_out = s.mode[0];
      end
      default:
      begin
        select_pin_oe = 1'b0;
      end
    endcase
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rstn);

  a_done_sets :
    assert property (set_done |=> s.done)
    else $error("Transfer done flag not set.");

  a_done_holds :
    assert property (s.done && !wmask[spi_cs_pkg::DONE_BIT] |=> s.done)
    else $error("Transfer done flag dropped without a write.");

  a_coll_sets :
    assert property (dat_wr && !s.txe |=> s.coll)
    else $error("Write collision flag not set.");

  a_coll_drops_write :
    assert property (dat_wr && !s.txe |=>
      $stable(s.txbuf) && $stable(s.wr_tgl) && (!s.txe || $past(ack_ev)))
    else $error("Colliding write changed the transmit buffer.");

  a_fault_sets :
    assert property (set_fault ##1 1'b1 |-> s.fault)
    else $error("Mode fault flag not set.");

  a_fault_needs_mode :
    assert property ($rose(s.fault) |-> $past(s.mode) == spi_cs_pkg::MODE_SELECT_IN ||
                     $past(wmask[spi_cs_pkg::FAULT_BIT]))
    else $error("Mode fault set outside select input mode.");

  a_ovr_slave_only :
    assert property ($rose(s.ovr) |-> !$past(master_enable) ||
                     $past(wmask[spi_cs_pkg::OVR_BIT]))
    else $error("Overrun flag set in master operation.");

  a_irq_follows :
    assert property (irq_enable && $rose(s.done) |-> irq_request)
    else $error("No interrupt request for a set flag.");

  a_sel_no_drive :
    assert property (!s.mode[1] |-> !select_pin_oe)
    else $error("Select pin driven in an input mode.");

  a_sel_drives :
    assert property (s.en && s.mode[1] |-> select_pin_oe && select_pin_out == s.mode[0])
    else $error("Select pin level differs from the mode low bit.");

  a_txe_clears :
    assert property (dat_wr && s.txe |=> !s.txe ##0 s.txbuf == $past(sfr_wdata))
    else $error("Accepted write did not fill the buffer.");

  a_txe_sets :
    assert property (ack_ev |=> s.txe)
    else $error("Buffer empty not set after a load.");

  a_set_wins :
    assert property (set_done && wmask[spi_cs_pkg::DONE_BIT] |=> s.done)
    else $error("Hardware set lost against a clear.");

  a_ovr_sets :
    assert property (set_ovr |=> s.ovr)
    else $error("Receive overrun flag not set.");

  a_sel_input :
    assert property (s.mode == spi_cs_pkg::MODE_SELECT_IN |->
      select_n_to_engine == sel_lvl && !select_pin_oe)
    else $error("Select input not passed to the engine.");

  a_off_no_done :
    assert property (!s.en && !wmask[spi_cs_pkg::DONE_BIT] |=> $stable(s.done))
    else $error("Transfer done flag changed while disabled.");

endmodule

// ### tb/link_engine_model.sv
/*
  Behavioural shift engine on the link clock: takes the offered byte,
  then strobes last bit and transfer end.
  Assumes the control logic offers bytes through tx_valid and tx_data.
*/
`timescale 1ns/1ns
module link_engine_model
(
  input  wire logic       link_clk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_load,
  output logic            xfer_end,
  output logic            last_bit
);
  initial
  begin
    tx_load  = 1'b0;
    xfer_end = 1'b0;
    last_bit = 1'b0;
  end

  // A gap of a few cycles answers promptly, a long gap plays a slow engine.
  task automatic run(input int gap, input bit load, output logic [7:0] got);
    int n;
    got = 8'h00;
    n = 0;
    if (load)
    begin
      while (tx_valid !== 1'b1 && n < 40)
      begin
        @(negedge link_clk);
        n++;
      end
      @(negedge link_clk);
      tx_load = 1'b1;
      @(posedge link_clk);
      got = tx_data;
      @(negedge link_clk);
      tx_load = 1'b0;
    end
    repeat (gap) @(negedge link_clk);
    last_bit = 1'b1;
    @(negedge link_clk);
    last_bit = 1'b0;
    repeat (2) @(negedge link_clk);
    xfer_end = 1'b1;
    @(negedge link_clk);
    xfer_end = 1'b0;
  endtask
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench of the control and status register: register tasks,
  flag, select pin and link transfer sequences.
  Assumes the engine model drives the link strobes.
*/
`timescale 1ns/1ns
module testbench;
  logic       clk, rstn, sfr_wr, sfr_bit_wr, sfr_bit_wdata, sfr_rd, sfr_rd_hit;
  logic       master_enable, rx_buffer_full, irq_enable, irq_request, port_enable;
  logic       select_pin_in, select_pin_out, select_pin_oe, select_n_to_engine;
  logic       link_clk, tx_load, xfer_end, last_bit, tx_valid;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, tx_data, got;
  int         err_total, tests_run;

  spi_control_status spi_control_status_inst
  (
    .clk, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_wdata,
    .sfr_rd, .sfr_rdata, .sfr_rd_hit, .master_enable, .rx_buffer_full,
    .irq_enable, .irq_request, .port_enable, .select_pin_in, .select_pin_out,
    .select_pin_oe, .select_n_to_engine, .link_clk, .tx_load, .xfer_end,
    .last_bit, .tx_valid, .tx_data
  );

  link_engine_model link_engine_model_inst
  (
    .link_clk, .tx_data, .tx_valid, .tx_load, .xfer_end, .last_bit
  );

  always #5 clk = ~clk;

  always
  begin
    #20 link_clk = 1'b1;
    #62 link_clk = 1'b0;
    #43;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic bwr(input logic [2:0] n, input logic v);
    @(negedge clk);
    sfr_addr      = {5'h1f, n};
    sfr_bit_wdata = v;
    sfr_bit_wr    = 1'b1;
    @(negedge clk);
    sfr_bit_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk("rd_hit", {7'h00, sfr_rd_hit}, {7'h00, hit});
    if (hit)
      chk("csr", sfr_rdata, exp);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #300000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    {clk, link_clk, rstn, sfr_wr, sfr_bit_wr, sfr_bit_wdata, sfr_rd} = 7'h00;
    {master_enable, rx_buffer_full} = 2'b00;
    {irq_enable, select_pin_in} = 2'b11;
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    rd(8'hf8, 8'h06, 1'b1);
    chk("irq", {7'h00, irq_request}, 8'h00);
    bwr(3'd0, 1'b1);
    rd(8'hf8, 8'h07, 1'b1);
    chk("en", {7'h00, port_enable}, 8'h01);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00, 1'b0);
    wr(8'hf8, 8'h05);
    rd(8'hf8, 8'h07, 1'b1);
    wr(8'ha3, 8'h5a);
    rd(8'hf8, 8'h05, 1'b1);
    wr(8'ha3, 8'hc3);
    rd(8'hf8, 8'h45, 1'b1);
    chk("tx_data", tx_data, 8'h5a);
    chk("irq", {7'h00, irq_request}, 8'h01);
    irq_enable = 1'b0;
    @(negedge clk);
    chk("irq", {7'h00, irq_request}, 8'h00);
    irq_enable = 1'b1;
    bwr(3'd6, 1'b0);
    rd(8'hf8, 8'h05, 1'b1);
    repeat (40) @(negedge clk);
    chk("tx_valid", {7'h00, tx_valid}, 8'h01);
    link_engine_model_inst.run(8, 1'b1, got);
    chk("byte", got, 8'h5a);
    chk("tx_valid", {7'h00, tx_valid}, 8'h00);
    repeat (8) @(negedge clk);
    rd(8'hf8, 8'h87, 1'b1);
    wr(8'hf8, 8'h07);
    rx_buffer_full = 1'b1;
    link_engine_model_inst.run(2, 1'b0, got);
    repeat (8) @(negedge clk);
    rd(8'hf8, 8'h97, 1'b1);
    rx_buffer_full = 1'b0;
    wr(8'hf8, 8'h07);
    rd(8'hf8, 8'h07, 1'b1);
    // Both select settings are tried with a low pin; only mode 01 may fault.
    master_enable = 1'b1;
    wr(8'hf8, 8'h03);
    select_pin_in = 1'b0;
    repeat (6) @(negedge clk);
    rd(8'hf8, 8'h03, 1'b1);
    chk("sel_n", {7'h00, select_n_to_engine}, 8'h00);
    wr(8'hf8, 8'h07);
    repeat (6) @(negedge clk);
    rd(8'hf8, 8'h27, 1'b1);
    chk("sel_n", {7'h00, select_n_to_engine}, 8'h00);
    select_pin_in = 1'b1;
    repeat (6) @(negedge clk);
    wr(8'hf8, 8'h07);
    rd(8'hf8, 8'h07, 1'b1);
    master_enable = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      wr(8'hf8, {4'h0, m[1:0], 2'b01});
      chk("oe", {7'h00, select_pin_oe}, {7'h00, m[1]});
      chk("sel_n", {7'h00, select_n_to_engine}, {7'h00, m == 1});
      if (m > 1)
        chk("out", {7'h00, select_pin_out}, {7'h00, m[0]});
    end
    wr(8'hf8, 8'h0c);
    chk("oe", {7'h00, select_pin_oe}, 8'h00);
    link_engine_model_inst.run(2, 1'b0, got);
    repeat (8) @(negedge clk);
    rd(8'hf8, 8'h0e, 1'b1);
    tally_and_finish();
  end
endmodule
